// [tcf_cfg.svh]
// Addresses, field positions, reset values and divider sizes of the timer block
`ifndef TCF_CFG_SVH
`define TCF_CFG_SVH

// ----------------------------------------------------------------------------
// Byte addresses on the peripheral bus
// ----------------------------------------------------------------------------
`define TCF_ADDR_CTRL 16'hffb6
`define TCF_ADDR_FLAGS 16'hffb7
`define TCF_ADDR_CNT_HI 16'hffb8
`define TCF_ADDR_CNT_LO 16'hffb9
`define TCF_ADDR_CMP_HI 16'hffba
`define TCF_ADDR_CMP_LO 16'hffbb

// ----------------------------------------------------------------------------
// Reset values and read answers
// ----------------------------------------------------------------------------
`define TCF_CTRL_RST 8'h00
`define TCF_FLAGS_RST 8'h00
`define TCF_CNT_RST 8'h00
`define TCF_CMP_RST 8'hff
`define TCF_BYTE_ONES 8'hff
`define TCF_RD_NONE 8'hff

// ----------------------------------------------------------------------------
// Field positions in timer_control_write
// ----------------------------------------------------------------------------
`define TCF_B_LVL_HI 7
`define TCF_B_HI_SEL2 6
`define TCF_B_LVL_LO 3

// ----------------------------------------------------------------------------
// Field positions in timer_flags_control
// ----------------------------------------------------------------------------
`define TCF_B_OVF_HI 7
`define TCF_B_CMP_HI 6
`define TCF_B_OVIE_HI 5
`define TCF_B_CLR_HI 4
`define TCF_B_OVF_LO 3
`define TCF_B_CMP_LO 2
`define TCF_B_OVIE_LO 1
`define TCF_B_CLR_LO 0

// ----------------------------------------------------------------------------
// Prescaler: low counter bits that must all be ones for each rate
// ----------------------------------------------------------------------------
`define TCF_DIV_W 5
`define TCF_DIV32_BITS 5
`define TCF_DIV16_BITS 4
`define TCF_DIV4_BITS 2
`define TCF_DIV2_BITS 1

`endif

// [tcf_clk_gen.sv]
// Prescaler and event-pin edge detector that make the two count enables
`timescale 1ns/10ps
`include "tcf_cfg.svh"

module tcf_clk_gen (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Event pin and its controls
   input wire logic event_in,
   input wire logic event_edge_sel,
   input wire logic event_pin_func_sel,
   // Selects in, enables out
   tcf_tick_if.gen tk
);

   logic [`TCF_DIV_W-1:0] div_cnt;
   logic [3:0] div_tick;
   logic ev_meta;
   logic ev_sync;
   logic ev_prev;
   logic pin_lvl;
   logic ev_tick;
   logic [1:0] tick;

   // ----------------------------------------------------------------------------
   // Free-running prescaler
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) div_cnt <= '0;
      else div_cnt <= div_cnt + 1'b1;
   end

   assign div_tick[0] = &div_cnt[`TCF_DIV32_BITS-1:0];
   assign div_tick[1] = &div_cnt[`TCF_DIV16_BITS-1:0];
   assign div_tick[2] = &div_cnt[`TCF_DIV4_BITS-1:0];
   assign div_tick[3] = &div_cnt[`TCF_DIV2_BITS-1:0];

   // ----------------------------------------------------------------------------
   // Event pin: synchroniser and edge detect
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ev_meta <= 1'b1;
         ev_sync <= 1'b1;
         ev_prev <= 1'b1;
      end else begin
         ev_meta <= event_in;
         ev_sync <= ev_meta;
         ev_prev <= pin_lvl;
      end
   end

   // Pin reads high when not in event function, so a switch while low gives an edge
   assign pin_lvl = event_pin_func_sel ? ev_sync : 1'b1;
   assign ev_tick = event_edge_sel ? (pin_lvl & ~ev_prev) : (~pin_lvl & ev_prev);

   // ----------------------------------------------------------------------------
   // Per-counter source select (0 = lower, 1 = upper)
   // ----------------------------------------------------------------------------
   for (genvar ch = 0; ch < 2; ch++) begin : g_src
      wire [2:0] sel = (ch == 1) ? tk.hi_sel : tk.lo_sel;
      wire ext = (ch == 1) ? 1'b0 : ev_tick;
      assign tick[ch] = sel[2] ? div_tick[sel[1:0]] : ext;
   end

   assign tk.tick_hi = tick[1];
   assign tk.tick_lo = tick[0];

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   property p_lo_div2;
      @(posedge clk) disable iff (!resetn)
      (tk.lo_sel == 3'b111) && tk.tick_lo |=> !tk.tick_lo;
   endproperty
   a_lo_div2: assert property (p_lo_div2) else $error("lower /2 enable too fast");

   property p_hi_div32;
      @(posedge clk) disable iff (!resetn)
      (tk.hi_sel == 3'b100) && tk.tick_hi |=> !tk.tick_hi [*8];
   endproperty
   a_hi_div32: assert property (p_hi_div32) else $error("upper /32 enable too fast");

endmodule

// [tcf_cpu_model.sv]
// CPU model that drives the timer's byte bus
`timescale 1ns/10ps
`include "tcf_cfg.svh"

module tcf_cpu_model (
   // Clock
   input wire logic clk,
   // Byte bus
   output logic [15:0] bus_addr,
   output logic bus_wr,
   output logic bus_rd,
   output tcf_pkg::tcf_byte_t bus_wdata,
   input wire tcf_pkg::tcf_byte_t bus_rdata
);
   initial begin
      bus_addr = 16'h0000;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = 8'h00;
   end

   // ------------------------------------------------------------------
   // Byte cycles: set at falling edge, released one cycle later
   // ------------------------------------------------------------------
   task automatic wr(input logic [15:0] a, input tcf_pkg::tcf_byte_t d);
      @(negedge clk);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge clk);
      bus_wr = 1'b0;
      bus_addr = ~a;
      bus_wdata = ~d;
   endtask

   task automatic rd(input logic [15:0] a, output tcf_pkg::tcf_byte_t d);
      @(negedge clk);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge clk);
      bus_rd = 1'b0;
      bus_addr = ~a;
      d = bus_rdata;
   endtask

   // Sixteen-bit write, upper byte first
   task automatic wr16(input logic [15:0] a_hi, input logic [15:0] d);
      wr(a_hi, d[15:8]);
      wr(a_hi + 16'h0001, d[7:0]);
   endtask
endmodule

// [tcf_pkg.sv]
// Shared types of the timer block
package tcf_pkg;

   typedef logic [7:0] tcf_byte_t;

   // Count source chosen by a three-bit select field
   typedef enum logic [2:0] {
      TCF_SRC_CHAIN,
      TCF_SRC_DIV32,
      TCF_SRC_DIV16,
      TCF_SRC_DIV4,
      TCF_SRC_DIV2
   } tcf_src_t;

endpackage

// [tcf_tick_if.sv]
// Clock-select fields out to the prescaler, count enables back
`timescale 1ns/10ps
interface tcf_tick_if;
   logic [2:0] hi_sel;
   logic [2:0] lo_sel;
   logic tick_hi;
   logic tick_lo;

   modport gen (
      input hi_sel,
      input lo_sel,
      output tick_hi,
      output tick_lo
   );

   modport core (
      output hi_sel,
      output lo_sel,
      input tick_hi,
      input tick_lo
   );
endinterface

// [tcf_timer.sv]
// Cascadable 16-bit / dual 8-bit compare timer with byte-wide CPU access
//
// Behaviour
// - Control register is write-only, eight bits, cleared by reset.
// - Control bit 7 sets upper toggle output level at once on write.
// - Control bit 3 sets lower toggle output level at once on write.
// - Bit 6 low: cascaded 16-bit mode, upper counts lower overflows.
// - Bit 6 high: upper counter uses /32, /16, /4 or /2 enable.
// - Bit 2 low: lower counter counts event pin edges, edge chosen outside.
// - Bit 2 high: lower counter uses /32, /16, /4 or /2 enable.
// - Changing pin function while event pin is low may add one count.
// - Flags register is read/write, eight bits, cleared by reset.
// - Bit 7 set when upper counter rolls from all ones to zero.
// - Bit 6 set when upper counter matches upper compare; in 16-bit mode only on a full 16-bit match.
// - Flags clear only by writing 0 after reading 1; writing 1 never sets.
// - Bits 5 and 1 enable the upper and lower overflow interrupts.
// - Bit 4 clears on match: full counter in 16-bit, upper in 8-bit.
// - Bit 3 set when lower counter rolls from all ones to zero.
// - Bit 2 set when lower counter matches lower compare.
// - Bit 0 clears lower counter on lower compare match in 8-bit mode.
// - An eight-bit byte latch carries 16-bit counter and compare accesses.
// - In 8-bit mode byte accesses work directly, in any order.
// - Upper byte write goes to latch; lower write loads both bytes together.
// - Upper counter read returns directly and latches lower for next read.
// - Compare reads bypass the latch, each byte straight from register.
// - In 16-bit mode upper overflow flag marks full 16-bit rollover.
// - Each compare match inverts the toggle output from its set level.
`timescale 1ns/10ps
`include "tcf_cfg.svh"

module tcf_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // CPU byte bus
   input wire logic [15:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire tcf_pkg::tcf_byte_t bus_wdata,
   output tcf_pkg::tcf_byte_t bus_rdata,
   // Pins
   input wire logic event_in,
   output logic toggle_out_hi,
   output logic toggle_out_lo,
   // Controls held outside the block
   input wire logic event_edge_sel,
   input wire logic event_pin_func_sel,
   // Interrupt requests
   output logic irq_ovf_hi,
   output logic irq_cmp_hi,
   output logic irq_ovf_lo,
   output logic irq_cmp_lo
);

   tcf_pkg::tcf_byte_t ctrl;
   tcf_pkg::tcf_byte_t flags;
   tcf_pkg::tcf_byte_t cnt_hi;
   tcf_pkg::tcf_byte_t cnt_lo;
   tcf_pkg::tcf_byte_t cmp_hi;
   tcf_pkg::tcf_byte_t cmp_lo;
   tcf_pkg::tcf_byte_t byte_latch;
   tcf_pkg::tcf_byte_t rd_val;
   logic [3:0] armed;
   logic [3:0] flag_set;

   tcf_tick_if tk ();

   // ----------------------------------------------------------------------------
   // Count enables
   // ----------------------------------------------------------------------------
   assign tk.hi_sel = ctrl[6:4];
   assign tk.lo_sel = ctrl[2:0];

   tcf_clk_gen u_clk_gen (
      .clk(clk),
      .resetn(resetn),
      .event_in(event_in),
      .event_edge_sel(event_edge_sel),
      .event_pin_func_sel(event_pin_func_sel),
      .tk(tk)
   );

   // ----------------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------------
   wire wide = ~ctrl[`TCF_B_HI_SEL2];
   wire w_ctrl = bus_wr && (bus_addr == `TCF_ADDR_CTRL);
   wire w_flags = bus_wr && (bus_addr == `TCF_ADDR_FLAGS);
   wire w_cnt_hi = bus_wr && (bus_addr == `TCF_ADDR_CNT_HI);
   wire w_cnt_lo = bus_wr && (bus_addr == `TCF_ADDR_CNT_LO);
   wire w_cmp_hi = bus_wr && (bus_addr == `TCF_ADDR_CMP_HI);
   wire w_cmp_lo = bus_wr && (bus_addr == `TCF_ADDR_CMP_LO);
   wire r_flags = bus_rd && (bus_addr == `TCF_ADDR_FLAGS);
   wire r_cnt_hi = bus_rd && (bus_addr == `TCF_ADDR_CNT_HI);

   // ----------------------------------------------------------------------------
   // Match, clear and overflow events
   // ----------------------------------------------------------------------------
   // Compare write in the same cycle suppresses the match
   wire lo_match = tk.tick_lo && (cnt_lo == cmp_lo) && !w_cmp_lo;
   wire full_match = wide && tk.tick_lo && ({cnt_hi, cnt_lo} == {cmp_hi, cmp_lo})
                     && !w_cmp_lo && !w_cmp_hi;
   wire clr_hi_en = flags[`TCF_B_CLR_HI];
   wire clr_lo_en = flags[`TCF_B_CLR_LO];
   wire lo_clr = wide ? (full_match && clr_hi_en) : (lo_match && clr_lo_en);
   // Counter write in the same cycle suppresses the overflow
   wire lo_ovf = tk.tick_lo && (cnt_lo == `TCF_BYTE_ONES) && !lo_clr && !w_cnt_lo;
   wire hi_tick = wide ? lo_ovf : tk.tick_hi;
   wire hi_match = wide ? full_match
                        : (tk.tick_hi && (cnt_hi == cmp_hi) && !w_cmp_hi);
   wire hi_clr = hi_match && clr_hi_en;
   wire hi_busy = w_cnt_hi || (wide && w_cnt_lo);
   wire hi_ovf = hi_tick && (cnt_hi == `TCF_BYTE_ONES) && !hi_clr && !hi_busy;

   // ----------------------------------------------------------------------------
   // Control register and toggle outputs
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) ctrl <= `TCF_CTRL_RST;
      else if (w_ctrl) ctrl <= bus_wdata;
   end

   // A control write wins over a match in the same cycle
   always_ff @(posedge clk) begin
      if (!resetn) begin
         toggle_out_hi <= 1'b0;
         toggle_out_lo <= 1'b0;
      end else if (w_ctrl) begin
         toggle_out_hi <= bus_wdata[`TCF_B_LVL_HI];
         toggle_out_lo <= bus_wdata[`TCF_B_LVL_LO];
      end else begin
         if (hi_match) toggle_out_hi <= ~toggle_out_hi;
         if (lo_match) toggle_out_lo <= ~toggle_out_lo;
      end
   end

   // ----------------------------------------------------------------------------
   // Counters; a CPU write wins over counting
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) cnt_lo <= `TCF_CNT_RST;
      else if (w_cnt_lo) cnt_lo <= bus_wdata;
      else if (lo_clr) cnt_lo <= '0;
      else if (tk.tick_lo) cnt_lo <= cnt_lo + 1'b1;
   end

   always_ff @(posedge clk) begin
      if (!resetn) cnt_hi <= `TCF_CNT_RST;
      else if (wide && w_cnt_lo) cnt_hi <= byte_latch;
      else if (!wide && w_cnt_hi) cnt_hi <= bus_wdata;
      else if (hi_clr) cnt_hi <= '0;
      else if (hi_tick) cnt_hi <= cnt_hi + 1'b1;
   end

   // ----------------------------------------------------------------------------
   // Compare registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cmp_hi <= `TCF_CMP_RST;
         cmp_lo <= `TCF_CMP_RST;
      end else begin
         if (w_cmp_lo) cmp_lo <= bus_wdata;
         if (wide && w_cmp_lo) cmp_hi <= byte_latch;
         else if (!wide && w_cmp_hi) cmp_hi <= bus_wdata;
      end
   end

   // ----------------------------------------------------------------------------
   // Byte latch for 16-bit access
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) byte_latch <= '0;
      else if (wide && (w_cnt_hi || w_cmp_hi)) byte_latch <= bus_wdata;
      else if (wide && r_cnt_hi) byte_latch <= cnt_lo;
   end

   // ----------------------------------------------------------------------------
   // Flags: set by events, cleared by writing 0 after a read of 1
   // ----------------------------------------------------------------------------
   assign flag_set = {hi_ovf, hi_match, lo_ovf, lo_match};

   for (genvar i = 0; i < 4; i++) begin : g_flag
      localparam int POS = (i < 2) ? (`TCF_B_CMP_LO + i) : (`TCF_B_CMP_HI + i - 2);
      wire clr_req = w_flags && armed[i] && !bus_wdata[POS];
      always_ff @(posedge clk) begin
         if (!resetn) begin
            flags[POS] <= 1'b0;
            armed[i] <= 1'b0;
         end else begin
            if (flag_set[i]) flags[POS] <= 1'b1;
            else if (clr_req) flags[POS] <= 1'b0;
            if (r_flags) armed[i] <= flags[POS];
            else if (w_flags) armed[i] <= 1'b0;
         end
      end
   end

   // Enable and clear-select bits are plain read/write
   for (genvar j = 0; j < 2; j++) begin : g_ctl
      localparam int BASE = j * 4;
      always_ff @(posedge clk) begin
         if (!resetn) flags[BASE+1:BASE] <= 2'(`TCF_FLAGS_RST >> BASE);
         else if (w_flags) flags[BASE+1:BASE] <= bus_wdata[BASE+1:BASE];
      end
   end

   assign irq_ovf_hi = flags[`TCF_B_OVF_HI] & flags[`TCF_B_OVIE_HI];
   assign irq_ovf_lo = flags[`TCF_B_OVF_LO] & flags[`TCF_B_OVIE_LO];
   assign irq_cmp_hi = flags[`TCF_B_CMP_HI];
   assign irq_cmp_lo = flags[`TCF_B_CMP_LO];

   // ----------------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------------
   always_comb begin
      case (bus_addr)
         `TCF_ADDR_FLAGS: rd_val = flags;
         `TCF_ADDR_CNT_HI: rd_val = cnt_hi;
         `TCF_ADDR_CNT_LO: rd_val = wide ? byte_latch : cnt_lo;
         `TCF_ADDR_CMP_HI: rd_val = cmp_hi;
         `TCF_ADDR_CMP_LO: rd_val = cmp_lo;
         default: rd_val = `TCF_RD_NONE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) bus_rdata <= '0;
      else if (bus_rd) bus_rdata <= rd_val;
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   property p_lvl_hi;
      @(posedge clk) disable iff (!resetn)
      w_ctrl |=> toggle_out_hi == $past(bus_wdata[`TCF_B_LVL_HI]);
   endproperty
   a_lvl_hi: assert property (p_lvl_hi) else $error("upper level not applied");

   property p_lvl_lo;
      @(posedge clk) disable iff (!resetn)
      w_ctrl |=> toggle_out_lo == $past(bus_wdata[`TCF_B_LVL_LO]);
   endproperty
   a_lvl_lo: assert property (p_lvl_lo) else $error("lower level not applied");

   property p_toggle_hi;
      @(posedge clk) disable iff (!resetn)
      hi_match && !w_ctrl |=> toggle_out_hi != $past(toggle_out_hi);
   endproperty
   a_toggle_hi: assert property (p_toggle_hi) else $error("upper output did not toggle");

   property p_ovf_hi_set;
      @(posedge clk) disable iff (!resetn)
      wide && lo_ovf && (cnt_hi == `TCF_BYTE_ONES) && !w_cnt_hi |=> flags[`TCF_B_OVF_HI];
   endproperty
   a_ovf_hi_set: assert property (p_ovf_hi_set) else $error("16-bit rollover not flagged");

   property p_no_sw_set;
      @(posedge clk) disable iff (!resetn)
      !flags[`TCF_B_CMP_LO] && !lo_match |=> !flags[`TCF_B_CMP_LO];
   endproperty
   a_no_sw_set: assert property (p_no_sw_set) else $error("flag set without event");

   property p_clear_after_read;
      @(posedge clk) disable iff (!resetn)
      r_flags && flags[`TCF_B_OVF_LO] ##1 !w_flags
      ##1 (w_flags && !bus_wdata[`TCF_B_OVF_LO] && !lo_ovf)
      |=> !flags[`TCF_B_OVF_LO];
   endproperty
   a_clear_after_read: assert property (p_clear_after_read) else $error("flag not cleared");

   property p_wr16;
      @(posedge clk) disable iff (!resetn)
      wide && w_cnt_lo |=> {cnt_hi, cnt_lo} == {$past(byte_latch), $past(bus_wdata)};
   endproperty
   a_wr16: assert property (p_wr16) else $error("16-bit write not atomic");

   property p_rd16;
      @(posedge clk) disable iff (!resetn)
      wide && r_cnt_hi && !bus_wr |=> byte_latch == $past(cnt_lo);
   endproperty
   a_rd16: assert property (p_rd16) else $error("lower byte not latched");

   property p_cmp_rd;
      @(posedge clk) disable iff (!resetn)
      bus_rd && (bus_addr == `TCF_ADDR_CMP_LO) |=> bus_rdata == $past(cmp_lo);
   endproperty
   a_cmp_rd: assert property (p_cmp_rd) else $error("compare read went through latch");

   property p_clr_lo;
      @(posedge clk) disable iff (!resetn)
      !wide && lo_match && clr_lo_en && !w_cnt_lo |=> cnt_lo == 8'h00;
   endproperty
   a_clr_lo: assert property (p_clr_lo) else $error("lower counter not cleared");

endmodule

// [tcf_timer_tb_top.sv]
// Self-checking testbench of the timer block
`timescale 1ns/10ps
`include "tcf_cfg.svh"

module tcf_timer_tb_top;
   logic clk, resetn, event_in, event_edge_sel, event_pin_func_sel, bus_wr, bus_rd;
   logic [15:0] bus_addr;
   tcf_pkg::tcf_byte_t bus_wdata, bus_rdata, v, w;
   logic toggle_out_hi, toggle_out_lo, irq_ovf_hi, irq_cmp_hi, irq_ovf_lo, irq_cmp_lo;
   int n_errors, cmp_count;
   int div_tab[4] = '{32, 16, 4, 2};

   tcf_timer tcf_timer_inst (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .event_in(event_in), .toggle_out_hi(toggle_out_hi), .toggle_out_lo(toggle_out_lo),
      .event_edge_sel(event_edge_sel), .event_pin_func_sel(event_pin_func_sel),
      .irq_ovf_hi(irq_ovf_hi), .irq_cmp_hi(irq_cmp_hi), .irq_ovf_lo(irq_ovf_lo),
      .irq_cmp_lo(irq_cmp_lo));

   tcf_cpu_model tcf_cpu_model_inst (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_rng(input string what, input int lo, input int hi, input logic [7:0] got);
      cmp_count++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0d..%0d seen %h", what, lo, hi, got);
      end
   endtask

   task automatic wr(input logic [15:0] a, input tcf_pkg::tcf_byte_t d);
      tcf_cpu_model_inst.wr(a, d);
   endtask

   task automatic rd(input logic [15:0] a);
      tcf_cpu_model_inst.rd(a, v);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset();
      rd(`TCF_ADDR_CTRL);
      chk("ctrl read", `TCF_RD_NONE, v);
      rd(`TCF_ADDR_FLAGS);
      chk("flags reset", `TCF_FLAGS_RST, v);
      rd(`TCF_ADDR_CMP_HI);
      chk("cmp hi reset", `TCF_CMP_RST, v);
      chk("toggles reset", 8'h00, {6'h00, toggle_out_hi, toggle_out_lo});
      $display("test reset done");
   endtask

   task automatic t_levels();
      wr(`TCF_ADDR_CTRL, 8'h80);
      chk("levels 80", 8'h02, {6'h00, toggle_out_hi, toggle_out_lo});
      wr(`TCF_ADDR_CTRL, 8'h08);
      chk("levels 08", 8'h01, {6'h00, toggle_out_hi, toggle_out_lo});
      wr(`TCF_ADDR_CTRL, 8'h00);
      $display("test levels done");
   endtask

   task automatic t_pair16();
      tcf_cpu_model_inst.wr16(`TCF_ADDR_CNT_HI, 16'haa55);
      rd(`TCF_ADDR_CNT_HI);
      chk("cnt hi", 8'haa, v);
      rd(`TCF_ADDR_CNT_LO);
      chk("cnt lo", 8'h55, v);
      tcf_cpu_model_inst.wr16(`TCF_ADDR_CMP_HI, 16'h1234);
      rd(`TCF_ADDR_CMP_LO);
      chk("cmp lo", 8'h34, v);
      rd(`TCF_ADDR_CMP_HI);
      chk("cmp hi", 8'h12, v);
      wr(`TCF_ADDR_CTRL, 8'h07);
      rd(`TCF_ADDR_CNT_HI);
      rd(`TCF_ADDR_CNT_LO);
      w = v;
      repeat (10) @(negedge clk);
      rd(`TCF_ADDR_CNT_LO);
      chk("latched lo", w, v);
      wr(`TCF_ADDR_CTRL, 8'h00);
      $display("test pair16 done");
   endtask

   task automatic t_order8();
      wr(`TCF_ADDR_CTRL, 8'h40);
      wr(`TCF_ADDR_CNT_LO, 8'h33);
      wr(`TCF_ADDR_CMP_LO, 8'h77);
      rd(`TCF_ADDR_CNT_LO);
      chk("lone lo", 8'h33, v);
      rd(`TCF_ADDR_CMP_LO);
      chk("cmp lo 8", 8'h77, v);
      $display("test order8 done");
   endtask

   task automatic t_flags_lo();
      wr(`TCF_ADDR_FLAGS, 8'hff);
      rd(`TCF_ADDR_FLAGS);
      chk("write ones", 8'h33, v);
      wr(`TCF_ADDR_FLAGS, 8'h02);
      wr(`TCF_ADDR_CMP_LO, 8'hff);
      wr(`TCF_ADDR_CTRL, 8'h47);
      wr(`TCF_ADDR_CNT_LO, 8'hfe);
      repeat (12) @(negedge clk);
      chk("toggle lo", 8'h01, {7'h00, toggle_out_lo});
      chk("irqs lo", 8'h03, {6'h00, irq_ovf_lo, irq_cmp_lo});
      rd(`TCF_ADDR_FLAGS);
      chk("flags lo", 8'h0e, v);
      wr(`TCF_ADDR_FLAGS, 8'h08);
      rd(`TCF_ADDR_FLAGS);
      chk("partial clear", 8'h08, v);
      chk("gated irq", 8'h00, {6'h00, irq_ovf_lo, irq_cmp_lo});
      wr(`TCF_ADDR_FLAGS, 8'h00);
      rd(`TCF_ADDR_FLAGS);
      chk("flags cleared", 8'h00, v);
      $display("test flags_lo done");
   endtask

   task automatic t_rates();
      for (int i = 0; i < 4; i++) begin
         wr(`TCF_ADDR_CTRL, 8'h44 | (8'(i) << 4) | 8'(i));
         wr(`TCF_ADDR_CNT_HI, 8'h00);
         wr(`TCF_ADDR_CNT_LO, 8'h00);
         repeat (64) @(negedge clk);
         rd(`TCF_ADDR_CNT_HI);
         chk_rng("rate hi", 64 / div_tab[i], 72 / div_tab[i] + 1, v);
         rd(`TCF_ADDR_CNT_LO);
         chk_rng("rate lo", 64 / div_tab[i], 72 / div_tab[i] + 1, v);
      end
      $display("test rates done");
   endtask

   task automatic t_hi8();
      wr(`TCF_ADDR_CTRL, 8'h77);
      wr(`TCF_ADDR_CMP_HI, 8'h03);
      wr(`TCF_ADDR_CMP_LO, 8'h01);
      rd(`TCF_ADDR_FLAGS);
      wr(`TCF_ADDR_FLAGS, 8'h11);
      wr(`TCF_ADDR_CNT_HI, 8'h00);
      wr(`TCF_ADDR_CNT_LO, 8'h00);
      repeat (40) @(negedge clk);
      rd(`TCF_ADDR_CNT_HI);
      chk_rng("clear hi", 0, 3, v);
      chk("irq cmp hi", 8'h01, {7'h00, irq_cmp_hi});
      rd(`TCF_ADDR_CNT_LO);
      chk_rng("clear lo", 0, 1, v);
      rd(`TCF_ADDR_FLAGS);
      chk("cmp hi flag", 8'h40, v & 8'h40);
      wr(`TCF_ADDR_FLAGS, 8'h00);
      wr(`TCF_ADDR_CNT_HI, 8'hfe);
      repeat (8) @(negedge clk);
      rd(`TCF_ADDR_FLAGS);
      chk("ovf hi 8", 8'h80, v & 8'h80);
      $display("test hi8 done");
   endtask

   task automatic t_ovf16();
      wr(`TCF_ADDR_CTRL, 8'h07);
      for (int i = 0; i < 2; i++) begin
         rd(`TCF_ADDR_FLAGS);
         wr(`TCF_ADDR_FLAGS, 8'h20);
         tcf_cpu_model_inst.wr16(`TCF_ADDR_CNT_HI, i == 0 ? 16'h00fe : 16'hfffe);
         repeat (10) @(negedge clk);
         rd(`TCF_ADDR_FLAGS);
         chk("ovf hi 16", i == 0 ? 8'h00 : 8'h80, v & 8'h80);
         chk("irq ovf hi", i == 0 ? 8'h00 : 8'h01, {7'h00, irq_ovf_hi});
         rd(`TCF_ADDR_CNT_HI);
         chk("carry hi", i == 0 ? 8'h01 : 8'h00, v);
      end
      $display("test ovf16 done");
   endtask

   task automatic t_event();
      wr(`TCF_ADDR_CTRL, 8'h40);
      wr(`TCF_ADDR_CNT_LO, 8'h00);
      for (int i = 0; i < 5; i++) begin
         event_edge_sel = (i < 3);
         event_in = 1'b0;
         repeat (4) @(negedge clk);
         event_in = 1'b1;
         repeat (4) @(negedge clk);
      end
      repeat (6) @(negedge clk);
      rd(`TCF_ADDR_CNT_LO);
      chk("event count", 8'h05, v);
      // Pin function switched while the pin is low adds one falling edge
      event_in = 1'b0;
      repeat (4) @(negedge clk);
      event_pin_func_sel = 1'b0;
      repeat (4) @(negedge clk);
      event_pin_func_sel = 1'b1;
      repeat (4) @(negedge clk);
      event_in = 1'b1;
      repeat (6) @(negedge clk);
      rd(`TCF_ADDR_CNT_LO);
      chk("func switch count", 8'h07, v);
      $display("test event done");
   endtask

   // ------------------------------------------------------------------
   // Sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      n_errors = 0;
      cmp_count = 0;
      resetn = 1'b0;
      event_in = 1'b1;
      event_edge_sel = 1'b1;
      event_pin_func_sel = 1'b1;
      repeat (16) @(negedge clk);
      resetn = 1'b1;
      t_reset();
      t_levels();
      t_pair16();
      t_order8();
      t_flags_lo();
      t_rates();
      t_hi8();
      t_ovf16();
      t_event();
      final_report();
   end

   initial begin
      #100us;
      n_errors++;
      $display("watchdog expired");
      final_report();
   end
endmodule
